// ==== dv/pfs_afe_model.sv ====
// pfs_afe_model: behavioural power stage and sensor front end.
// assumes the bench sets supply, temperature, peak current and prebias.
`timescale 1ns/10ps
module pfs_afe_model #(
  parameter int SW_PERIOD = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // from the supervisor
  input wire logic drivers_en,
  input wire logic [15:0] vref,
  // bench levels
  input wire logic [15:0] vin_set,
  input wire logic [15:0] temp_set,
  input wire logic [15:0] ipeak_set,
  input wire logic [15:0] pb_set,
  input wire logic [15:0] ov_set,
  // digitized measurements
  output pfs_pkg::pfs_meas_t meas,
  output logic sw_cycle
);
  import pfs_pkg::*;
  logic [15:0] vout_q;
  int cnt_q;
  // output tracks the reference one cycle late, else shows the prebias
  always_ff @(posedge core_clk) begin
    vout_q <= drivers_en ? vref : pb_set;
  end
  // free running modulator, so pulses arrive whether or not drivers run
  always_ff @(posedge core_clk) begin
    cnt_q <= (reset || cnt_q == SW_PERIOD - 1) ? 0 : cnt_q + 1;
    sw_cycle <= !reset && cnt_q == SW_PERIOD - 1;
  end
  // codes share the limit encodings: 10 mV and 1 degC per lsb
  assign meas = '{vin: vin_set, vout_diff: (ov_set != 16'h0000) ? ov_set : vout_q,
    temp: temp_set, iout_avg: 16'h0100, ipeak: ipeak_set, fsw_khz: 16'h01F4};
endmodule // pfs_afe_model

// ==== dv/pfs_supervisor_sva.sv ====
// pfs_supervisor_sva: port assertions for the fault supervisor.
// assumes default limits and a 1.00 V target that software never rewrites.
`timescale 1ns/10ps
module pfs_supervisor_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // front end
  input wire pfs_pkg::pfs_meas_t meas,
  input wire logic sw_cycle,
  // power stage
  input wire logic drivers_en,
  input wire logic [15:0] vref,
  input wire logic power_good_output,
  input wire logic [6:0] bus_address
);
  import pfs_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [1:0] oc_run_q;
  // successive switching cycles with peak current pinned at full scale
  always_ff @(posedge core_clk) begin
    if (reset || (sw_cycle && meas.ipeak != 16'hFFFF)) oc_run_q <= 2'h0;
    else if (sw_cycle && oc_run_q != 2'h3) oc_run_q <= oc_run_q + 2'h1;
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence oc_third_s;
    drivers_en && sw_cycle && meas.ipeak == 16'hFFFF && oc_run_q == 2'h2;
  endsequence
  bus_ack_a: assert property (bus_req_s |=> wb_ack_o)
    else $error("bus request not answered after one wait state");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  addr_hold_a: assert property (!$past(reset, 2) && !$past(reset) |-> $stable(bus_address))
    else $error("bus address moved after strap sampling");
  ov_stop_a: assert property (drivers_en && meas.vout_diff > 16'h0073 |=> !drivers_en)
    else $error("overvoltage did not stop the drivers");
  ot_stop_a: assert property (drivers_en && meas.temp > 16'h007D |=> !drivers_en)
    else $error("over-temperature did not stop the drivers");
  uv_stop_a: assert property (drivers_en && meas.vin < 16'h01C2 |=> !drivers_en)
    else $error("undervoltage did not stop the drivers");
  oc_stop_a: assert property (oc_third_s |=> !drivers_en)
    else $error("third peak current cycle did not stop the drivers");
  pg_drv_a: assert property (power_good_output |-> drivers_en && $past(drivers_en))
    else $error("power good without drivers");
  start_ref_a: assert property ($rose(drivers_en) |-> vref == meas.vout_diff)
    else $error("reference did not start at prebias");
  pg_ref_a: assert property ($rose(power_good_output) |-> ##[0:2] vref == 16'h0064)
    else $error("reference not at target after power good");
endmodule // pfs_supervisor_sva

// ==== dv/tb_pfs_supervisor.sv ====
// tb_pfs_supervisor: self-checking bench for the fault supervisor.
// assumes the package, the design and the dv models are compiled first.
`timescale 1ns/10ps
module tb_pfs_supervisor;
  import pfs_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic sw_cycle, drivers_en, power_good_output;
  logic [15:0] vref, vin = 16'h04B0, temp = 16'h0019, ipeak = 16'h0, pb = 16'h0, ov = 16'h0;
  logic [5:0] address_strap_pin = 6'h00, ss = 6'h00;
  logic [6:0] bus_address;
  pfs_meas_t meas;
  int num_errors = 0;
  int num_checks = 0;
  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;
  pfs_supervisor i_dut (.core_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .meas, .sw_cycle, .address_strap_pin,
    .softstart_lockout_strap_pin(ss), .drivers_en, .vref, .power_good_output, .bus_address);
  pfs_afe_model #(.SW_PERIOD(8)) i_afe (.core_clk, .reset, .drivers_en, .vref, .vin_set(vin),
    .temp_set(temp), .ipeak_set(ipeak), .pb_set(pb), .ov_set(ov), .meas, .sw_cycle);
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled; waits only on the bench limit
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb_xfer(1'b0, a, 32'h0);
    chk(rd & 32'h0000FFFF, exp);
  endtask
  task automatic go(input logic [31:0] cfg);
    wb_xfer(1'b1, PFS_OFS_CTRL, cfg);
    while (power_good_output !== 1'b1) begin
      @(posedge core_clk);
    end
  endtask
  task automatic pulses(input int k);
    while (k > 0) begin
      @(posedge core_clk);
      if (sw_cycle === 1'b1) k--;
    end
  endtask
  // a latched fault must keep the stage off; disabling clears it afterwards
  task automatic hold_off(input logic [31:0] flags);
    repeat (400) @(posedge core_clk);
    chk(32'(drivers_en), 32'h0);
    wb_xfer(1'b0, PFS_OFS_STATUS, 32'h0);
    chk(rd & 32'hF, flags);
    wb_xfer(1'b1, PFS_OFS_CTRL, 32'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin : main
    logic [5:0] st [5] = '{6'h00, 6'h3F, 6'h01, 6'h1F, 6'h0E};
    logic [6:0] ad [5] = '{7'h26, 7'h28, 7'h19, 7'h37, 7'h26};
    for (int i = 0; i < 5; i++) begin
      address_strap_pin <= st[i];
      reset <= 1'b1;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk(32'(bus_address), 32'(ad[i]));
    end
    $display("test strap address done");
    rchk(PFS_OFS_OT_FLT, 32'h007D);
    rchk(PFS_OFS_OT_WARN, 32'h0069);
    rchk(PFS_OFS_OV_FLT, 32'h0073);
    wb_xfer(1'b1, 8'h30, 32'h0000FFFF);
    rchk(8'h30, 32'h0);
    ss <= 6'h0B;
    wb_xfer(1'b1, PFS_OFS_CTRL, 32'h4);
    rchk(PFS_OFS_UV_FLT, 32'h0438);
    wb_xfer(1'b1, PFS_OFS_CTRL, 32'h0);
    wb_xfer(1'b1, PFS_OFS_UV_FLT, 32'h0010);
    rchk(PFS_OFS_UV_FLT, 32'h01A2);
    wb_xfer(1'b1, PFS_OFS_UV_FLT, 32'hFFFF);
    rchk(PFS_OFS_UV_FLT, 32'h0640);
    wb_xfer(1'b1, PFS_OFS_UV_FLT, 32'h01C2);
    rchk(PFS_OFS_UV_WARN, 32'h01D8);
    $display("test registers done");
    go(32'h0401);
    chk(32'(power_good_output), 32'h1);
    chk(32'(vref), 32'h0064);
    pulses(1);
    ipeak <= 16'hFFFF;
    pulses(2);
    ipeak <= 16'h0;
    pulses(2);
    chk(32'(drivers_en), 32'h1);
    ipeak <= 16'hFFFF;
    pulses(3);
    ipeak <= 16'h0;
    hold_off(32'h4);
    $display("test overcurrent done");
    go(32'h0401);
    temp <= 16'h007D;
    repeat (20) @(posedge core_clk);
    chk(32'(drivers_en), 32'h1);
    temp <= 16'h007E;
    hold_off(32'h8);
    temp <= 16'h0019;
    $display("test temperature done");
    wb_xfer(1'b1, PFS_OFS_RESP, 32'h000F);
    go(32'h0403);
    vin <= 16'h01C1;
    repeat (2) @(posedge core_clk);
    vin <= 16'h04B0;
    hold_off(32'h1);
    go(32'h0401);
    vin <= 16'h01C1;
    repeat (2) @(posedge core_clk);
    vin <= 16'h04B0;
    rchk(PFS_OFS_STATUS, 32'h0401);
    wb_xfer(1'b1, PFS_OFS_CTRL, 32'h0);
    wb_xfer(1'b1, PFS_OFS_RESP, 32'h0);
    $display("test undervoltage done");
    go(32'h0401);
    ov <= 16'h0073;
    repeat (5) @(posedge core_clk);
    chk(32'(drivers_en), 32'h1);
    ov <= 16'h0074;
    @(posedge core_clk);
    ov <= 16'h0;
    hold_off(32'h2);
    $display("test overvoltage done");
    pb <= 16'h006E;
    go(32'h0401);
    chk(32'(power_good_output), 32'h1);
    repeat (3) @(posedge core_clk);
    chk(32'(vref), 32'h0064);
    wb_xfer(1'b1, PFS_OFS_CTRL, 32'h0);
    pb <= 16'h0080;
    wb_xfer(1'b1, PFS_OFS_CTRL, 32'h0401);
    hold_off(32'h2);
    $display("test prebias done");
    finish_test();
  end
  // watchdog sized well beyond the expected run
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    $display("watchdog expired");
    finish_test();
  end
endmodule // tb_pfs_supervisor
bind pfs_supervisor pfs_supervisor_sva i_sva (.core_clk, .reset, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .meas, .sw_cycle, .drivers_en, .vref, .power_good_output, .bus_address);

// ==== verilog/pfs_pkg.sv ====
// pfs_pkg: register map, encodings and timing constants of the fault supervisor.
// assumes a 40 MHz core clock and a classic wishbone register bus.
package pfs_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] PFS_OFS_CTRL     = 8'h00;
  localparam logic [7:0] PFS_OFS_UV_FLT   = 8'h04;
  localparam logic [7:0] PFS_OFS_UV_WARN  = 8'h08;
  localparam logic [7:0] PFS_OFS_OV_FLT   = 8'h0C;
  localparam logic [7:0] PFS_OFS_OC_FLT   = 8'h10;
  localparam logic [7:0] PFS_OFS_OT_FLT   = 8'h14;
  localparam logic [7:0] PFS_OFS_OT_WARN  = 8'h18;
  localparam logic [7:0] PFS_OFS_VTARGET  = 8'h1C;
  localparam logic [7:0] PFS_OFS_RESP     = 8'h20;
  localparam logic [7:0] PFS_OFS_STATUS   = 8'h24;
  localparam logic [7:0] PFS_OFS_REF      = 8'h28;
  localparam logic [7:0] PFS_OFS_ADDR     = 8'h2C;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PFS_CTRL_ENABLE = 0;
  localparam int PFS_CTRL_SHARE = 1;
  localparam int PFS_CTRL_UV_STRAP = 2;
  localparam int PFS_CTRL_RAMP_LSB = 8;
  localparam int PFS_RESP_UV = 0;
  localparam int PFS_RESP_OV = 1;
  localparam int PFS_RESP_OC = 2;
  localparam int PFS_RESP_OT = 3;
  localparam int PFS_RESP_DLY_LSB = 4;
  localparam int PFS_RAMP_W = 16;

  // ****************************************************************
  // measurement codes: 1 lsb = 10 mV for volts, 1 lsb = 1 degC for temperature
  // ****************************************************************
  localparam int PFS_MW = 16;
  localparam logic [15:0] PFS_UV_MIN = 16'h01A2;     // 4.18 V
  localparam logic [15:0] PFS_UV_MAX = 16'h0640;     // 16 V
  localparam logic [15:0] PFS_UV_STRAP_LO = 16'h01C2; // 4.5 V
  localparam logic [15:0] PFS_UV_STRAP_HI = 16'h0438; // 10.8 V
  localparam logic [15:0] PFS_UV_RST = 16'h01C2;
  localparam logic [15:0] PFS_OT_RST = 16'h007D;     // +125 degC
  localparam logic [15:0] PFS_OTW_RST = 16'h0069;    // +105 degC
  localparam logic [15:0] PFS_VT_RST = 16'h0064;     // 1.0 V target
  localparam logic [15:0] PFS_OC_RST = 16'h2000;
  localparam logic [15:0] PFS_RAMP_RST = 16'h0FA0;   // ramp ticks of 1 us
  localparam logic [1:0] PFS_OC_COUNT = 2'h3;        // successive cycles

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int PFS_CLK_HZ = 40000000;
  localparam int PFS_TICK_US = 1;
  localparam int PFS_TICK_CYC = PFS_CLK_HZ / 1000000 * PFS_TICK_US;
  localparam int PFS_RETRY_STEP_MS = 35;             // delay code 0..7 -> 35..280 ms
  localparam int PFS_RETRY_STEP_TICKS = PFS_RETRY_STEP_MS * 1000 / PFS_TICK_US;

  // ****************************************************************
  // strap codes: adc index of the strap resistor, 0 = ground, 63 = open
  // ****************************************************************
  localparam logic [5:0] PFS_SA_GND = 6'h00;
  localparam logic [5:0] PFS_SA_OPEN = 6'h3F;
  localparam logic [5:0] PFS_SA_LAST = 6'h1E;        // 31 listed resistors
  localparam logic [6:0] PFS_ADDR_BASE = 7'h19;
  localparam logic [6:0] PFS_ADDR_GND = 7'h26;
  localparam logic [6:0] PFS_ADDR_OPEN = 7'h28;
  localparam logic [5:0] PFS_SS_HI_FIRST = 6'h0B;    // first index of the high uv band
  localparam logic [5:0] PFS_SS_HI_LAST = 6'h12;

  typedef enum logic [6:0] {
    PFS_OFF = 7'b0000001,
    PFS_DELAY = 7'b0000010,
    PFS_RAMP = 7'b0000100,
    PFS_SETTLE = 7'b0001000,
    PFS_ON = 7'b0010000,
    PFS_FAULT = 7'b0100000,
    PFS_RETRY = 7'b1000000
  } pfs_state_t;

  // digitized measurements from the analog front end
  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vout_diff;
    logic [15:0] temp;
    logic [15:0] iout_avg;
    logic [15:0] ipeak;
    logic [15:0] fsw_khz;
  } pfs_meas_t;

  // fault flags
  typedef struct packed {
    logic ot;
    logic oc;
    logic ov;
    logic uv;
  } pfs_flt_t;

endpackage

// ==== verilog/pfs_supervisor.sv ====
// pfs_supervisor: fault supervision, prebias start-up and strap decoding.
// assumes measurements synchronous to core_clk, one sw_cycle pulse per switching period.
// How it works
// - uv fault limit register is clamped to 4.18 V .. 16 V codes.
// - in strap mode, softstart strap index picks 4.5 V or 10.8 V lockout.
// - with uv retry, output stops at once; recheck after 35..280 ms delay.
// - uv retry restarts only when input rises above uv warning level.
// - uv warning defaults to 1.05 times lockout, and is writable.
// - current sharing mode disables every retry; faults latch off.
// - address strap index maps ascending to addresses 19h through 37h.
// - grounded strap gives 26h, open strap gives 28h.
// - ov limit defaults to target plus 15 percent, writable.
// - differential output above ov limit shuts down at once, no retry by default.
// - ov response bit enables continuous retry with 35..280 ms delay.
// - output voltage sampled before the ramp starts, for prebias.
// - prebias below target: reference starts at prebias, ramps to target on time.
// - prebias above target below ov: reference starts at prebias, drivers on.
// - power good at ramp end; above-target case then steps reference to target.
// - prebias above ov limit: no turn-on, ov fault, ov response applies.
// - average oc limit writable; peak limit computed from vin, fsw, vout.
// - peak current over limit three successive cycles shuts down at once.
// - oc retry off by default, enabled by vendor overcurrent response bit.
// - temperature above ot limit shuts down; limit defaults to 125 degC.
// - ot retry off by default, enabled by response bit, 35..280 ms delay.
// - ot retry restarts only below ot warning, default 105 degC.
`timescale 1ns/10ps
module pfs_supervisor (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // analog front end
  input wire pfs_pkg::pfs_meas_t meas,
  input wire logic sw_cycle,
  input wire logic [5:0] address_strap_pin,
  input wire logic [5:0] softstart_lockout_strap_pin,
  // power stage
  output logic drivers_en,
  output logic [15:0] vref,
  output logic power_good_output,
  output logic [6:0] bus_address
);
  import pfs_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // clamp a write to the legal uv window
  function automatic logic [15:0] clamp_uv(input logic [15:0] v);
    if (v < PFS_UV_MIN) begin
      return PFS_UV_MIN;
    end else if (v > PFS_UV_MAX) begin
      return PFS_UV_MAX;
    end
    return v;
  endfunction

  // byte-lane merge of a 16 bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [31:0] ctrl_q;
  logic [15:0] uv_flt_q, uv_warn_q, ov_flt_q, oc_flt_q, ot_flt_q, ot_warn_q, vtarget_q;
  logic [7:0] resp_q;
  logic ov_custom_q, uvw_custom_q;
  pfs_flt_t flt_q;
  pfs_state_t state_q;
  logic [15:0] ref_q, prebias_q;
  logic above_q;
  logic [31:0] cnt_q;
  logic [5:0] tick_q;
  logic [1:0] oc_run_q;
  logic [6:0] addr_q;
  logic strap_done_q;

  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire tick = (tick_q == 6'(PFS_TICK_CYC - 1));
  wire sharing = ctrl_q[PFS_CTRL_SHARE];

  // ****************************************************************
  // bus slave: one wait state, ack drops the cycle after
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // read mux, unmapped reads as zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wb_dat_o <= 32'h0;
    end else begin
      case (wb_adr_i)
        PFS_OFS_CTRL: wb_dat_o <= ctrl_q;
        PFS_OFS_UV_FLT: wb_dat_o <= {16'h0, uv_flt_q};
        PFS_OFS_UV_WARN: wb_dat_o <= {16'h0, uv_warn_q};
        PFS_OFS_OV_FLT: wb_dat_o <= {16'h0, ov_flt_q};
        PFS_OFS_OC_FLT: wb_dat_o <= {16'h0, oc_flt_q};
        PFS_OFS_OT_FLT: wb_dat_o <= {16'h0, ot_flt_q};
        PFS_OFS_OT_WARN: wb_dat_o <= {16'h0, ot_warn_q};
        PFS_OFS_VTARGET: wb_dat_o <= {16'h0, vtarget_q};
        PFS_OFS_RESP: wb_dat_o <= {24'h0, resp_q};
        PFS_OFS_STATUS: wb_dat_o <= {21'h0, state_q, flt_q};
        PFS_OFS_REF: wb_dat_o <= {prebias_q, ref_q};
        PFS_OFS_ADDR: wb_dat_o <= {25'h0, addr_q};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // limit registers
  // ****************************************************************
  // lockout source: strap or bus write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      uv_flt_q <= PFS_UV_RST;
    end else if (wr && wb_adr_i == PFS_OFS_UV_FLT) begin
      uv_flt_q <= clamp_uv(merge16(uv_flt_q, wb_dat_i, wb_sel_i));
    end else if (ctrl_q[PFS_CTRL_UV_STRAP]) begin
      // strap mode follows the pin; a bus write in that mode lasts one cycle only
      if (softstart_lockout_strap_pin >= PFS_SS_HI_FIRST &&
          softstart_lockout_strap_pin <= PFS_SS_HI_LAST) begin
        uv_flt_q <= PFS_UV_STRAP_HI;
      end else begin
        uv_flt_q <= PFS_UV_STRAP_LO;
      end
    end
  end

  // warning tracks 1.05 x lockout until written (x + x/20)
  always_ff @(posedge core_clk) begin
    if (reset) begin
      uvw_custom_q <= 1'b0;
      uv_warn_q <= 16'h0;
    end else if (wr && wb_adr_i == PFS_OFS_UV_WARN) begin
      uvw_custom_q <= 1'b1;
      uv_warn_q <= merge16(uv_warn_q, wb_dat_i, wb_sel_i);
    end else if (!uvw_custom_q) begin
      uv_warn_q <= 16'(uv_flt_q + uv_flt_q / 16'd20);
    end
  end

  // ov limit follows target + 15 percent until written
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ov_custom_q <= 1'b0;
      ov_flt_q <= 16'h0;
    end else if (wr && wb_adr_i == PFS_OFS_OV_FLT) begin
      ov_custom_q <= 1'b1;
      ov_flt_q <= merge16(ov_flt_q, wb_dat_i, wb_sel_i);
    end else if (!ov_custom_q) begin
      ov_flt_q <= 16'(vtarget_q + (vtarget_q * 16'd3) / 16'd20);
    end
  end

  // remaining plain registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= {8'h0, PFS_RAMP_RST, 8'h0};
      oc_flt_q <= PFS_OC_RST;
      ot_flt_q <= PFS_OT_RST;
      ot_warn_q <= PFS_OTW_RST;
      vtarget_q <= PFS_VT_RST;
      resp_q <= 8'h0;
    end else if (wr) begin
      case (wb_adr_i)
        PFS_OFS_CTRL: ctrl_q <= {8'h0, merge16(ctrl_q[23:8], wb_dat_i >> 8, wb_sel_i >> 1),
                                 (wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_q[7:0])};
        PFS_OFS_OC_FLT: oc_flt_q <= merge16(oc_flt_q, wb_dat_i, wb_sel_i);
        PFS_OFS_OT_FLT: ot_flt_q <= merge16(ot_flt_q, wb_dat_i, wb_sel_i);
        PFS_OFS_OT_WARN: ot_warn_q <= merge16(ot_warn_q, wb_dat_i, wb_sel_i);
        PFS_OFS_VTARGET: vtarget_q <= merge16(vtarget_q, wb_dat_i, wb_sel_i);
        PFS_OFS_RESP: resp_q <= wb_sel_i[0] ? wb_dat_i[7:0] : resp_q;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // address strap decode, once after reset release
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      strap_done_q <= 1'b0;
      addr_q <= PFS_ADDR_OPEN;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      if (address_strap_pin == PFS_SA_GND) begin
        addr_q <= PFS_ADDR_GND;
      end else if (address_strap_pin == PFS_SA_OPEN || address_strap_pin > PFS_SA_LAST + 6'h1) begin
        addr_q <= PFS_ADDR_OPEN;
      end else begin
        addr_q <= 7'(PFS_ADDR_BASE + 7'(address_strap_pin - 6'h1));
      end
    end
  end
  assign bus_address = addr_q;

  // ****************************************************************
  // fault detection
  // ****************************************************************
  // peak limit: average limit plus half ripple, ripple ~ (vin-vout)*vout/(vin*fsw)
  logic [15:0] ipk_lim;
  logic [31:0] ripple;
  always_comb begin
    ripple = 32'h0;
    if (meas.vin > vtarget_q && meas.vin != 16'h0 && meas.fsw_khz != 16'h0) begin
      ripple = (32'(meas.vin - vtarget_q) * 32'(vtarget_q)) /
               (32'(meas.vin) * 32'(meas.fsw_khz) / 32'd1000 + 32'd1);
    end
    ipk_lim = 16'(oc_flt_q + 16'(ripple[16:1]));
  end

  // successive switching cycles above the peak limit
  always_ff @(posedge core_clk) begin
    if (reset || state_q == PFS_OFF || state_q == PFS_FAULT) begin
      oc_run_q <= 2'h0;
    end else if (sw_cycle) begin
      if (meas.ipeak > ipk_lim) begin
        oc_run_q <= (oc_run_q == PFS_OC_COUNT) ? oc_run_q : 2'(oc_run_q + 2'h1);
      end else begin
        oc_run_q <= 2'h0;
      end
    end
  end

  wire running = state_q == PFS_RAMP || state_q == PFS_SETTLE || state_q == PFS_ON;
  pfs_flt_t det;
  always_comb begin
    det.uv = running && meas.vin < uv_flt_q;
    det.ov = running && meas.vout_diff > ov_flt_q;
    det.oc = running && sw_cycle && meas.ipeak > ipk_lim &&
             oc_run_q == 2'(PFS_OC_COUNT - 2'h1);
    det.ot = running && meas.temp > ot_flt_q;
  end

  // retry allowed when every active fault has its retry bit and no sharing
  wire retry_ok = !sharing &&
    (!flt_q.uv || resp_q[PFS_RESP_UV]) && (!flt_q.ov || resp_q[PFS_RESP_OV]) &&
    (!flt_q.oc || resp_q[PFS_RESP_OC]) && (!flt_q.ot || resp_q[PFS_RESP_OT]);
  // restart gate: input above warning, temperature below warning
  wire clear_ok = (!flt_q.uv || meas.vin > uv_warn_q) &&
                  (!flt_q.ot || meas.temp < ot_warn_q);
  wire [31:0] retry_ticks = 32'(PFS_RETRY_STEP_TICKS) *
                            32'({1'b0, resp_q[PFS_RESP_DLY_LSB +: 3]} + 4'h1);
  wire [15:0] ramp_ticks = ctrl_q[PFS_CTRL_RAMP_LSB +: PFS_RAMP_W];

  // ****************************************************************
  // microsecond tick
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset || tick) begin
      tick_q <= 6'h0;
    end else begin
      tick_q <= 6'(tick_q + 6'h1);
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= PFS_OFF;
      flt_q <= '0;
      cnt_q <= 32'h0;
      ref_q <= 16'h0;
      prebias_q <= 16'h0;
      above_q <= 1'b0;
    end else begin
      case (state_q)
        PFS_OFF: begin
          ref_q <= 16'h0;
          if (ctrl_q[PFS_CTRL_ENABLE] && meas.vin >= uv_flt_q) begin
            cnt_q <= 32'h0;
            state_q <= PFS_DELAY;
          end
        end
        PFS_DELAY: begin
          // sample output before any ramp
          prebias_q <= meas.vout_diff;
          if (meas.vout_diff > ov_flt_q) begin
            flt_q.ov <= 1'b1;
            cnt_q <= 32'h0;
            state_q <= PFS_FAULT;
          end else begin
            ref_q <= meas.vout_diff;
            above_q <= meas.vout_diff > vtarget_q;
            cnt_q <= 32'h0;
            state_q <= PFS_RAMP;
          end
        end
        PFS_RAMP: begin
          // linear interpolation so the ramp ends on time whatever the prebias
          if (tick) begin
            cnt_q <= 32'(cnt_q + 32'h1);
            if (!above_q && ramp_ticks != 16'h0) begin
              ref_q <= 16'(prebias_q + 16'((32'(vtarget_q - prebias_q) * (cnt_q + 32'h1))
                       / 32'(ramp_ticks)));
            end
          end
          if (cnt_q >= 32'(ramp_ticks)) begin
            state_q <= PFS_SETTLE;
          end
        end
        PFS_SETTLE: begin
          ref_q <= vtarget_q;
          state_q <= PFS_ON;
        end
        PFS_ON: begin
          ref_q <= vtarget_q;
          if (!ctrl_q[PFS_CTRL_ENABLE]) begin
            state_q <= PFS_OFF;
          end
        end
        PFS_FAULT: begin
          ref_q <= 16'h0;
          cnt_q <= 32'h0;
          if (retry_ok && ctrl_q[PFS_CTRL_ENABLE]) begin
            state_q <= PFS_RETRY;
          end else if (!ctrl_q[PFS_CTRL_ENABLE]) begin
            flt_q <= '0;
            state_q <= PFS_OFF;
          end
        end
        PFS_RETRY: begin
          if (tick && cnt_q < retry_ticks) begin
            cnt_q <= 32'(cnt_q + 32'h1);
          end
          if (!ctrl_q[PFS_CTRL_ENABLE]) begin
            flt_q <= '0;
            state_q <= PFS_OFF;
          end else if (cnt_q >= retry_ticks && clear_ok) begin
            flt_q <= '0;
            cnt_q <= 32'h0;
            state_q <= PFS_DELAY;
          end
        end
        default: state_q <= PFS_OFF;
      endcase
      // immediate shutdown overrides any running state
      if (running && det != '0) begin
        flt_q <= flt_q | det;
        ref_q <= 16'h0;
        state_q <= PFS_FAULT;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign drivers_en = running;
  assign vref = ref_q;
  assign power_good_output = state_q == PFS_SETTLE || state_q == PFS_ON;

endmodule // pfs_supervisor
